// *** design/mmd_consts.vh ***
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH

// Address map, 18-bit physical byte addresses.
`define MMD_AW            18
`define MMD_ROM_LO        18'h00000
`define MMD_ROM_HI        18'h01fff
`define MMD_VEC_HI        18'h000bf
`define MMD_RAM_LO        18'h0fa00
`define MMD_RAM_HI        18'h0fdff
`define MMD_PTR_LO        18'h0fde0
`define MMD_RAMBIT_LO     18'h0fd00
`define MMD_SFR_LO        18'h0fe00
`define MMD_SFR_HI        18'h0ffff
`define MMD_SFRBIT_LO     18'h0ff00
`define MMD_SFRBIT_HI     18'h0ffdf
`define MMD_TOP           18'h3ffff
`define MMD_BANK_SPAN     18'h0001f
`define MMD_PAGE_ZERO     2'h0
`define MMD_SEG_ZERO      2'h0
`define MMD_VEC_MAX       6'h2f
`define MMD_SYNC_CNT      2'h2

// Bus type encodings.
`define MMD_BT_OFF        2'h0
`define MMD_BT_8BIT       2'h1

// APB register offsets.
`define MMD_OFF_CFG       12'h000
`define MMD_OFF_STAT      12'h004

// Configuration register fields.
`define MMD_CFG_ROM_ENABLE_FLAG     0
`define MMD_CFG_BT_LO     1
`define MMD_CFG_BT_HI     2
`define MMD_CFG_SEGOFF    3

// Error cause bit positions.
`define MMD_E_ALIGN       0
`define MMD_E_FETCH       1
`define MMD_E_BIT         2
`define MMD_E_ROMMODE     3
`define MMD_E_EXTOFF      4
`define MMD_E_VEC         5
`define MMD_EW            6

`endif

// *** design/mmd_decoder.v ***
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_consts.vh"

module mmd_decoder (
   input  wire        pclk,            // System clock, 100 MHz.
   input  wire        presetn,         // Asynchronous reset, active low.
   input  wire        psel,            // APB select.
   input  wire        penable,         // APB access phase.
   input  wire        pwrite,          // APB direction, high for write.
   input  wire [11:0] paddr,           // APB byte address.
   input  wire [31:0] pwdata,          // APB write data.
   output reg  [31:0] prdata,          // APB read data.
   output wire        pready,          // APB ready, always high.
   output wire        pslverr,         // APB error for unmapped offsets.
   input  wire        bus_cfg_pin_hi,  // Bus configuration pin, high bit.
   input  wire        bus_cfg_pin_lo,  // Bus configuration pin, low bit.
   input  wire        acc_valid,       // Access request strobe.
   output wire        acc_ready,       // High once configuration is captured.
   input  wire [17:0] acc_addr,        // Access byte address.
   input  wire        acc_fetch,       // Instruction fetch.
   input  wire        acc_word,        // Word access, else byte.
   input  wire        acc_bit,         // Single-bit access.
   input  wire [3:0]  acc_bitnum,      // Bit number within the word.
   input  wire        acc_short,       // Short addressing mode.
   input  wire [1:0]  acc_page,        // Page designated by data_page_pointer.
   input  wire        acc_pec,         // Event transfer engine access.
   input  wire        vec_req,         // Vector branch request.
   input  wire [5:0]  vec_num,         // Vector number.
   input  wire [17:0] context_pointer, // Base of active register bank.
   output reg         res_valid,       // Result pulse.
   output reg  [17:0] res_addr,        // Physical byte address.
   output reg         sel_rom,         // Route to internal ROM.
   output reg         sel_ram,         // Route to internal RAM.
   output reg         sel_sfr,         // Route to special function regs.
   output reg         sel_ext,         // Start an external bus cycle.
   output reg         ext_bus16,       // External data path is 16 bits.
   output reg         be_lo,           // Even byte lane enabled.
   output reg         be_hi,           // Odd byte lane enabled.
   output reg  [2:0]  bit_pos,         // Bit position within the lane.
   output reg         in_vec_area,     // Address lies in vector table.
   output reg         in_ptr_area,     // Address lies in pointer area.
   output reg         acc_err,         // Access refused.
   output reg  [5:0]  err_cause        // Reason for refusal.
);

   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   // One-hot codes, one bit per state.
   localparam [1:0] ST_WAIT = 2'b01;   // Configuration pins being sampled.
   localparam [1:0] ST_RUN  = 2'b10;   // Normal decoding.

   // Capture sequencing.
   reg  [1:0]  st_r;                   // One-hot state.
   reg  [1:0]  st_nxt;                 // Next state.
   reg  [1:0]  cnt_r;                  // Sampling delay counter.

   // Both pins share one synchroniser.
   reg  [1:0]  pin_s1_r;               // First synchroniser stage.
   reg  [1:0]  pin_s2_r;               // Second synchroniser stage.

   // Captured and software configuration.
   reg         rom_enable_flag;        // Internal ROM enable, read-only.
   reg         ext_off_at_reset_r;     // External disabled by the pins.
   reg  [1:0]  bus_type_field;         // Saved bus configuration.
   reg         segmentation_off_bit;   // Confine external to segment 0.

   // Snapshot of the last taken request.
   reg  [5:0]  last_cause_r;           // Sticky-free copy of last request's causes.
   reg  [3:0]  last_sel_r;             // Last decoded region, also for refusals.

   // APB decode terms.
   wire        apb_wr;                 // Write takes effect this edge.
   wire        hit_cfg;                // Configuration offset hit.
   wire        hit_stat;               // Status offset hit.

   // Decode results of this cycle.
   reg  [17:0] ea;                     // Effective address.
   reg  [17:0] bank_top;               // Last byte of register bank.
   reg         is_rom;                 // Decoded region flags.
   reg         is_ram;
   reg         is_sfr;
   reg         is_ext;
   reg         bit_ok;                 // Bit access allowed here.
   reg  [5:0]  cause;                  // Refusal causes.

   //---------------------------------------------------------------------------
   // Range helper, used by every region test.
   //---------------------------------------------------------------------------
   // Both bounds are inclusive.
   function in_rng;
      input [17:0] a;
      input [17:0] lo;
      input [17:0] hi;
      begin
         in_rng = (a >= lo) && (a <= hi);
      end
   endfunction

   //---------------------------------------------------------------------------
   // Configuration pin synchroniser
   //---------------------------------------------------------------------------
   // The pins come from outside, so they pass two flops before use.
   // Only the second stage is read by other logic.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 2'h0;
         pin_s2_r <= 2'h0;
      end else begin
         // The high pin lands in bit 1.
         pin_s1_r <= {bus_cfg_pin_hi, bus_cfg_pin_lo};
         pin_s2_r <= pin_s1_r;
      end
   end

   //---------------------------------------------------------------------------
   // Capture state machine
   //---------------------------------------------------------------------------
   // Waits for the synchroniser to fill before latching the pins once.
   // The count runs 0, 1, 2; the pins latch on the third edge.
   always @* begin
      case (st_r)
         // Leave once the synchroniser is full.
         ST_WAIT: begin
            st_nxt = (cnt_r == `MMD_SYNC_CNT) ? ST_RUN : ST_WAIT;
         end
         // Running lasts until the next reset.
         ST_RUN: begin
            st_nxt = ST_RUN;
         end
         // An illegal code restarts the capture.
         default: begin
            st_nxt = ST_WAIT;
         end
      endcase
   end

   // The counter only moves while waiting.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r  <= ST_WAIT;
         cnt_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         if (st_r == ST_WAIT) begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end

   // Requests are not taken until then.
   assign acc_ready = (st_r == ST_RUN);

   //---------------------------------------------------------------------------
   // System configuration register
   //---------------------------------------------------------------------------
   // A write lands as the access phase ends.
   assign apb_wr  = psel & penable & pwrite;
   assign hit_cfg = (paddr == `MMD_OFF_CFG);
   assign hit_stat = (paddr == `MMD_OFF_STAT);

   // The ROM enable bit has no write path at all, so software cannot change it.
   // Writes during the capture are dropped.
   // The bus type may be rewritten freely while unlocked.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_enable_flag      <= 1'b0;
         ext_off_at_reset_r   <= 1'b1;
         bus_type_field       <= `MMD_BT_OFF;
         segmentation_off_bit <= 1'b0;
      end else if (st_r == ST_WAIT) begin
         // The pins are captured once.
         if (cnt_r == `MMD_SYNC_CNT) begin
            // Both pins low: ROM on, external off.
            rom_enable_flag    <= (pin_s2_r == 2'h0);
            ext_off_at_reset_r <= (pin_s2_r == 2'h0);
            bus_type_field     <= pin_s2_r;
         end
      end else if (apb_wr && hit_cfg) begin
         // Segmentation may change at any time.
         segmentation_off_bit <= pwdata[`MMD_CFG_SEGOFF];
         // Bus type stays locked when the pins enabled external memory.
         if (ext_off_at_reset_r) begin
            bus_type_field <= pwdata[`MMD_CFG_BT_HI:`MMD_CFG_BT_LO];
         end
      end
   end

   //---------------------------------------------------------------------------
   // APB read path
   //---------------------------------------------------------------------------
   // The slave never waits, so every access completes in its access phase.
   // Unmapped offsets error, read zero, drop writes.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~(hit_cfg | hit_stat);

   always @* begin
      prdata = 32'h0;
      // Unused bits read as zero.
      if (hit_cfg) begin
         prdata[`MMD_CFG_ROM_ENABLE_FLAG]                 = rom_enable_flag;
         prdata[`MMD_CFG_BT_HI:`MMD_CFG_BT_LO] = bus_type_field;
         prdata[`MMD_CFG_SEGOFF]                = segmentation_off_bit;
      end else if (hit_stat) begin
         // Causes and region of the last taken request.
         prdata[5:0] = last_cause_r;
         prdata[11:8] = last_sel_r;
      end
   end

   //---------------------------------------------------------------------------
   // Address decode
   //---------------------------------------------------------------------------
   // One combinational decode serves both data accesses and vector branches.
   // Only physical addresses are seen here.
   always @* begin
      // Vector requests branch to a fixed low address, whatever the
      // code_segment_pointer holds.
      if (vec_req) begin
         ea = {10'h0, vec_num, 2'h0};
      end else if (segmentation_off_bit) begin
         ea = {`MMD_SEG_ZERO, acc_addr[15:0]};
      end else begin
         ea = acc_addr;
      end
      // The active bank spans 32 bytes.
      bank_top = context_pointer + `MMD_BANK_SPAN;
      // Low 8K goes to ROM or, with ROM disabled, outward.
      is_rom = rom_enable_flag && in_rng(ea, `MMD_ROM_LO, `MMD_ROM_HI);
      is_ram = in_rng(ea, `MMD_RAM_LO, `MMD_RAM_HI);
      is_sfr = in_rng(ea, `MMD_SFR_LO, `MMD_SFR_HI);
      // Whatever is not internal goes outward.
      is_ext = !is_rom && !is_ram && !is_sfr
               && in_rng(ea, `MMD_ROM_LO, `MMD_TOP);
      // Bits: upper registers, upper RAM, bank.
      bit_ok = in_rng(ea, `MMD_SFRBIT_LO, `MMD_SFRBIT_HI)
               || in_rng(ea, `MMD_RAMBIT_LO, `MMD_RAM_HI)
               || in_rng(ea, context_pointer, bank_top);
      // Any single cause refuses the access.
      cause = 6'h0;
      // Fetches and words must sit on even addresses.
      if ((vec_req || acc_fetch || acc_word) && ea[0]) begin
         cause[`MMD_E_ALIGN] = 1'b1;
      end
      // Registers hold no code.
      if (!vec_req && acc_fetch && is_sfr) begin
         cause[`MMD_E_FETCH] = 1'b1;
      end
      // ROM is never bit-addressable.
      if (!vec_req && acc_bit && (!bit_ok || is_rom)) begin
         cause[`MMD_E_BIT] = 1'b1;
      end
      // ROM data needs long or indirect mode with page 0; event transfers
      // carry their own pointers and skip both the mode and the page check.
      if (!vec_req && !acc_fetch && !acc_bit && is_rom && !acc_pec
          && (acc_short || acc_page != `MMD_PAGE_ZERO)) begin
         cause[`MMD_E_ROMMODE] = 1'b1;
      end
      // External off: no bus cycle may start.
      if (is_ext && bus_type_field == `MMD_BT_OFF) begin
         cause[`MMD_E_EXTOFF] = 1'b1;
      end
      // Numbers past the table are refused.
      if (vec_req && vec_num > `MMD_VEC_MAX) begin
         cause[`MMD_E_VEC] = 1'b1;
      end
   end

   //---------------------------------------------------------------------------
   // Result register
   //---------------------------------------------------------------------------
   // A result appears one cycle after the request; a refused access raises
   // no select, so nothing downstream starts a cycle for it.
   // Data outputs hold until the next request.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid    <= 1'b0;
         res_addr     <= 18'h0;
         sel_rom      <= 1'b0;
         sel_ram      <= 1'b0;
         sel_sfr      <= 1'b0;
         sel_ext      <= 1'b0;
         ext_bus16    <= 1'b0;
         be_lo        <= 1'b0;
         be_hi        <= 1'b0;
         bit_pos      <= 3'h0;
         in_vec_area  <= 1'b0;
         in_ptr_area  <= 1'b0;
         acc_err      <= 1'b0;
         err_cause    <= 6'h0;
         last_cause_r <= 6'h0;
         last_sel_r   <= 4'h0;
      end else begin
         // Pulses clear unless a request is taken.
         res_valid <= acc_ready && (acc_valid || vec_req);
         sel_rom   <= 1'b0;
         sel_ram   <= 1'b0;
         sel_sfr   <= 1'b0;
         sel_ext   <= 1'b0;
         be_lo     <= 1'b0;
         be_hi     <= 1'b0;
         acc_err   <= 1'b0;
         if (acc_ready && (acc_valid || vec_req)) begin
            res_addr    <= ea;
            err_cause   <= cause;
            acc_err     <= (cause != 6'h0);
            // Status keeps a copy for software.
            last_cause_r <= cause;
            last_sel_r  <= {is_ext, is_sfr, is_ram, is_rom};
            // Area flags are kept for refusals too.
            in_vec_area <= in_rng(ea, `MMD_ROM_LO, `MMD_VEC_HI);
            in_ptr_area <= in_rng(ea, `MMD_PTR_LO, `MMD_RAM_HI);
            // Only bus type 01 is narrow.
            ext_bus16   <= (bus_type_field != `MMD_BT_8BIT);
            // The lane picks the byte, these the bit.
            bit_pos     <= acc_bitnum[2:0];
            // Only an accepted access is routed.
            if (cause == 6'h0) begin
               // Route to the one decoded target.
               sel_rom <= is_rom;
               sel_ram <= is_ram;
               sel_sfr <= is_sfr;
               sel_ext <= is_ext;
               // Words use both lanes; bytes and bits pick one.
               if (acc_word || acc_fetch || vec_req) begin
                  be_lo <= 1'b1;
                  be_hi <= 1'b1;
               end else if (acc_bit) begin
                  be_lo <= ~acc_bitnum[3];
                  be_hi <= acc_bitnum[3];
               end else begin
                  be_lo <= ~ea[0];
                  be_hi <= ea[0];
               end
            end
         end
      end
   end

endmodule

`default_nettype wire

// *** tb/mmd_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the decoder.
// ----------------------------------------------------------------------
module mmd_checker (
   input wire logic        pclk,        // System clock.
   input wire logic        presetn,     // Reset, active low.
   input wire logic        acc_valid,   // Access request.
   input wire logic        vec_req,     // Vector request.
   input wire logic        acc_ready,   // Decoder ready.
   input wire logic        res_valid,   // Result pulse.
   input wire logic [17:0] res_addr,    // Result address.
   input wire logic        sel_rom,     // ROM route.
   input wire logic        sel_ram,     // RAM route.
   input wire logic        sel_sfr,     // Register route.
   input wire logic        sel_ext,     // External route.
   input wire logic        be_lo,       // Even lane.
   input wire logic        be_hi,       // Odd lane.
   input wire logic        acc_err,     // Refusal.
   input wire logic        in_vec_area, // Vector table flag.
   input wire logic        in_ptr_area  // Pointer area flag.
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Every taken request gets exactly one result one cycle later.
   a_take_answer: assert property (
      acc_ready && (acc_valid || vec_req) |=> res_valid)
      else $error("No result after a taken request.");
   a_no_spurious: assert property (
      !(acc_ready && (acc_valid || vec_req)) |=> !res_valid)
      else $error("Result without a request.");
   // The pins need time to settle, so no request is taken at once.
   a_ready_wait: assert property (
      $rose(presetn) |-> !acc_ready [*2])
      else $error("Ready too early after reset.");
   a_err_quiet: assert property (
      res_valid && acc_err |-> !(sel_rom || sel_ram || sel_sfr || sel_ext || be_lo || be_hi))
      else $error("Refused access still routed.");
   a_one_route: assert property (
      res_valid && !acc_err |-> $onehot({sel_rom, sel_ram, sel_sfr, sel_ext}))
      else $error("Accepted access not routed to one target.");
   a_rom_range: assert property (
      sel_rom |-> res_addr <= 18'h01fff)
      else $error("ROM selected outside its range.");
   a_ram_range: assert property (
      sel_ram |-> res_addr >= 18'h0fa00 && res_addr <= 18'h0fdff)
      else $error("RAM selected outside its range.");
   a_sfr_range: assert property (
      sel_sfr |-> res_addr >= 18'h0fe00 && res_addr <= 18'h0ffff)
      else $error("Registers selected outside their range.");
   a_word_even: assert property (
      res_valid && be_lo && be_hi |-> !res_addr[0])
      else $error("Word access at an odd address.");
   a_vec_flag: assert property (
      res_valid |-> in_vec_area == (res_addr <= 18'h000bf))
      else $error("Vector area flag wrong.");
   a_ptr_flag: assert property (
      res_valid |-> in_ptr_area == (res_addr >= 18'h0fde0 && res_addr <= 18'h0fdff))
      else $error("Pointer area flag wrong.");

   c_rom: cover property (sel_rom);
   c_ext: cover property (sel_ext);
   c_err: cover property (res_valid && acc_err);
   c_ptr: cover property (res_valid && in_ptr_area);
endmodule
`default_nettype wire

// *** tb/mmd_ext_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// External bus controller model: counts the cycles it is asked to run.
// ----------------------------------------------------------------------
module mmd_ext_model (
   input  wire logic       pclk,      // System clock.
   input  wire logic       presetn,   // Reset, active low.
   input  wire logic       sel_ext,   // External cycle start.
   output var  logic [7:0] ext_cycles // Cycles started since reset.
);
   // A start while disabled would show up here as an extra count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_cycles <= 8'h00;
      end else if (sel_ext) begin
         ext_cycles <= ext_cycles + 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for the decoder.
// ----------------------------------------------------------------------
module tb;
   localparam logic [29:0] FE = 30'h1 << 18; // Fetch.
   localparam logic [29:0] WD = 30'h1 << 19; // Word.
   localparam logic [29:0] BT = 30'h1 << 20; // Single bit.
   localparam logic [29:0] SH = 30'h1 << 25; // Short mode.
   localparam logic [29:0] P1 = 30'h1 << 26; // Page one.
   localparam logic [29:0] PC = 30'h1 << 28; // Event transfer.
   localparam logic [29:0] VQ = 30'h1 << 29; // Vector request.
   localparam logic [3:0]  RO = 4'h8;        // ROM route.
   localparam logic [3:0]  RA = 4'h4;        // RAM route.
   localparam logic [3:0]  SF = 4'h2;        // Register route.
   localparam logic [3:0]  EX = 4'h1;        // External route.
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        bus_cfg_pin_hi, bus_cfg_pin_lo, acc_valid, acc_ready;
   logic        acc_fetch, acc_word, acc_bit, acc_short, acc_pec, vec_req;
   logic [17:0] acc_addr, context_pointer, res_addr;
   logic [3:0]  acc_bitnum;
   logic [1:0]  acc_page;
   logic [5:0]  vec_num, err_cause;
   logic        res_valid, sel_rom, sel_ram, sel_sfr, sel_ext, ext_bus16;
   logic        be_lo, be_hi, in_vec_area, in_ptr_area, acc_err;
   logic [2:0]  bit_pos;
   logic [7:0]  ext_cycles;
   logic [34:0] exp_q[$];
   logic [34:0] e, g;
   int          failures, n_compared, k;

   mmd_decoder i_mmd_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus_cfg_pin_hi, .bus_cfg_pin_lo, .acc_valid, .acc_ready,
      .acc_addr, .acc_fetch, .acc_word, .acc_bit, .acc_bitnum, .acc_short, .acc_page,
      .acc_pec, .vec_req, .vec_num, .context_pointer, .res_valid, .res_addr, .sel_rom,
      .sel_ram, .sel_sfr, .sel_ext, .ext_bus16, .be_lo, .be_hi, .bit_pos, .in_vec_area,
      .in_ptr_area, .acc_err, .err_cause);
   mmd_ext_model i_mmd_ext_model (.pclk, .presetn, .sel_ext, .ext_cycles);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test;
      $display("Comparisons %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic note(input logic ok, input string m);
      n_compared++;
      if (!ok) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask

   task automatic expire;
      note(1'b0, "wait expired");
      finish_test;
   endtask

   // Expected results, accepted or refused, carry address, route, lanes and error cause.
   function automatic logic [34:0] ex(input logic [3:0] s, input logic [1:0] b,
                                      input logic [5:0] c, input logic [17:0] a);
      return {4'h0, a, s, b, |c, c};
   endfunction

   function automatic logic [34:0] exb(input logic [2:0] p, input logic [3:0] s,
                                       input logic [1:0] b, input logic [17:0] a);
      return {1'b1, p, a, s, b, 7'h00};
   endfunction

   // Drives one access for one cycle and notes what must come back.
   task automatic go(input logic [29:0] r, input logic [34:0] x);
      @(posedge pclk);
      acc_valid  <= !r[29];
      vec_req    <= r[29];
      vec_num    <= r[5:0];
      acc_addr   <= r[17:0];
      acc_fetch  <= r[18];
      acc_word   <= r[19];
      acc_bit    <= r[20];
      acc_bitnum <= r[24:21];
      acc_short  <= r[25];
      acc_page   <= r[27:26];
      acc_pec    <= r[28];
      exp_q.push_back(x);
      @(posedge pclk);
      acc_valid <= 1'b0;
      vec_req   <= 1'b0;
   endtask

   // One APB transfer; d is the read value expected on reads.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic er);
      int i;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) expire;
      if (!w) note(prdata === d, "register read");
      note(pslverr === er, "slave error flag");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reset with the given strap pins, then wait for the capture.
   task automatic rst(input logic [1:0] pins);
      int i;
      @(posedge pclk);
      presetn <= 1'b0;
      {bus_cfg_pin_hi, bus_cfg_pin_lo} <= pins;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (acc_ready === 1'b1) break;
      end
      if (i == 20) expire;
   endtask

   // Result monitor: the oldest note is compared with each result pulse.
   always @(posedge pclk) begin
      if (res_valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : ~35'h0;
         g = {e[34], e[34] ? bit_pos : 3'h0, res_addr, sel_rom, sel_ram, sel_sfr, sel_ext,
              be_lo, be_hi, acc_err, err_cause};
         note(g === e, "access result");
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, acc_valid, vec_req, acc_fetch, acc_word} = 8'h00;
      {acc_bit, acc_short, acc_pec, bus_cfg_pin_hi, bus_cfg_pin_lo} = 5'h00;
      {paddr, pwdata, acc_addr, acc_bitnum, acc_page, vec_num} = '0;
      context_pointer = 18'h0fa40;
      failures = 0;
      n_compared = 0;
      void'($urandom(14892));
      rst(2'b00);
      apb(1'b0, 12'h000, 32'h1, 1'b0);
      go(FE | 18'h00100, ex(RO, 3, 0, 18'h00100));
      go(WD | 18'h01ffe, ex(RO, 3, 0, 18'h01ffe));
      go(WD | SH | 18'h01000, ex(0, 0, 6'h08, 18'h01000));
      go(P1 | 18'h01001, ex(0, 0, 6'h08, 18'h01001));
      go(PC | SH | P1 | 18'h01001, ex(RO, 1, 0, 18'h01001));
      go(WD | 18'h0fa10, ex(RA, 3, 0, 18'h0fa10));
      go(18'h0fa11, ex(RA, 1, 0, 18'h0fa11));
      go(FE | 18'h0fe00, ex(0, 0, 6'h02, 18'h0fe00));
      go(18'h0fe00, ex(SF, 2, 0, 18'h0fe00));
      go(WD | 18'h02000, ex(0, 0, 6'h10, 18'h02000));
      go(BT | (30'd15 << 21) | 18'h0ff00, exb(3'd7, SF, 1, 18'h0ff00));
      go(BT | 18'h0fd00, exb(3'd0, RA, 2, 18'h0fd00));
      go(BT | (30'd3 << 21) | 18'h0fa50, exb(3'd3, RA, 2, 18'h0fa50));
      go(BT | 18'h0fc00, ex(0, 0, 6'h04, 18'h0fc00));
      go(BT | 18'h00100, ex(0, 0, 6'h04, 18'h00100));
      go(WD | 18'h0fa11, ex(0, 0, 6'h01, 18'h0fa11));
      go(WD | 18'h0fde0, ex(RA, 3, 0, 18'h0fde0));
      go(VQ | 18'h00002, ex(RO, 3, 0, 18'h00008));
      go(VQ | 18'h00030, ex(0, 0, 6'h20, 18'h000c0));
      apb(1'b0, 12'h004, 32'h120, 1'b0);
      for (k = 0; k < 4; k++) begin
         g[17:0] = 18'h0fa00 + {$urandom % 256, 1'b0};
         go(WD | g[17:0], ex(RA, 3, 0, g[17:0]));
      end
      apb(1'b1, 12'h000, 32'h4, 1'b0);
      apb(1'b0, 12'h000, 32'h5, 1'b0);
      go(WD | 18'h02000, ex(EX, 3, 0, 18'h02000));
      apb(1'b1, 12'h000, 32'hc, 1'b0);
      go(WD | 18'h32000, ex(EX, 3, 0, 18'h02000));
      apb(1'b0, 12'h008, 32'h0, 1'b1);
      repeat (2) @(posedge pclk);
      note(ext_cycles === 8'h02, "external cycle count");
      note(ext_bus16 === 1'b1, "external path width");
      rst(2'b01);
      apb(1'b0, 12'h000, 32'h2, 1'b0);
      apb(1'b1, 12'h000, 32'h5, 1'b0);
      apb(1'b0, 12'h000, 32'h2, 1'b0);
      go(FE | 18'h00100, ex(EX, 3, 0, 18'h00100));
      go(VQ | 18'h00002, ex(EX, 3, 0, 18'h00008));
      go(WD | 18'h3fffe, ex(EX, 3, 0, 18'h3fffe));
      go(WD | 18'h0f9fe, ex(EX, 3, 0, 18'h0f9fe));
      repeat (2) @(posedge pclk);
      note(ext_cycles === 8'h04, "external cycle count");
      note(ext_bus16 === 1'b0, "external path width");
      note(exp_q.size() == 0, "results missing");
      finish_test;
   end

   // Watchdog for a hung run.
   initial begin
      repeat (20000) @(posedge pclk);
      expire;
   end
endmodule

bind mmd_decoder mmd_checker i_mmd_checker (.pclk, .presetn, .acc_valid, .vec_req,
   .acc_ready, .res_valid, .res_addr, .sel_rom, .sel_ram, .sel_sfr, .sel_ext, .be_lo,
   .be_hi, .acc_err, .in_vec_area, .in_ptr_area);
`default_nettype wire
